// File: verilog/bank_guard_cfg.svh
`ifndef BANK_GUARD_CFG_SVH
`define BANK_GUARD_CFG_SVH

// ==========================================================
// Timing counts, in link clock cycles except RAS_MAX_NS, which is in ns
// ==========================================================
`define RC_FAST        32
`define RC_SLOW        28
`define RAS_MIN_FAST   22
`define RAS_MIN_SLOW   20
`define RAS_MAX_NS     64000
`define RP_FAST        10
`define RP_SLOW        8
`define PP_MIN         8
`define RR_MIN         8
`define RCD_FAST       9
`define RCD_SLOW       7
`define RCD_CORE_EXTRA 1
`define CAC_FAST       9
`define CAC_SLOW       8
`define CAC_MAX        12
`define CWD_CYC        6
`define CC_MIN         4
`define PACKET_CYC     4
`define RTR_MIN        8
`define OFFP_CYC       4
`define RDP_MIN        4
`define RTP_MIN        4

// ==========================================================
// Defaults and widths
// ==========================================================
`define LINK_PERIOD_NS 125
`define BANK_COUNT     32
`define CNT_W          16
`define LAT_W          4

`endif

// File: verilog/bank_guard_pkg.sv
package bank_guard_pkg;

  // Row packet operations
  typedef enum logic [0:0] {
    ROW_BANK_ACTIVATE = 1'b0,
    ROW_PRECHARGE     = 1'b1
  } row_op_type;

  // Column / mask / extended packet operations
  typedef enum logic [2:0] {
    COL_READ                  = 3'b000,
    COL_WRITE                 = 3'b001,
    COL_READ_AUTO_PRECHARGE   = 3'b010,
    COL_RETIRE                = 3'b011,
    COL_RETIRE_AUTO_PRECHARGE = 3'b100,
    COL_COLUMN_PRECHARGE      = 3'b101,
    COL_EXTENDED_PRECHARGE    = 3'b110,
    COL_BYTE_MASK             = 3'b111
  } col_op_type;

  // Bit positions of the violation vector
  typedef enum logic [3:0] {
    V_RC = 4'h0, V_RAS_MIN = 4'h1, V_RAS_MAX = 4'h2, V_RP = 4'h3,
    V_RCD = 4'h4, V_RDP = 4'h5, V_RTP = 4'h6, V_PP = 4'h7,
    V_RR = 4'h8, V_CC = 4'h9, V_RTR = 4'hA, V_CWD = 4'hB
  } viol_type;

endpackage

// File: verilog/bank_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "bank_guard_cfg.svh"

module bank_timer #(
  parameter int CNT_W    = `CNT_W,
  parameter int RC_CYC   = `RC_FAST,
  parameter int RAS_CYC  = `RAS_MIN_FAST,
  parameter int RASX_CYC = 512,
  parameter int RP_CYC   = `RP_FAST,
  parameter int RCD_CYC  = `RCD_FAST
) (
  // Clock and reset (link domain)
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // Per-bank events
  input  wire logic act_in,
  input  wire logic pre_in,
  input  wire logic rw_in,
  input  wire logic rd_in,
  input  wire logic retire_in,
  // Violation pulses: rc, ras_min, ras_max, rp, rcd, rdp, rtp
  output logic [6:0] viol_out
);

  localparam logic [CNT_W-1:0] SAT = {CNT_W{1'b1}};

  logic [CNT_W-1:0] act_cnt_reg, act_cnt_next;
  logic [CNT_W-1:0] pre_cnt_reg, pre_cnt_next;
  logic [CNT_W-1:0] rd_cnt_reg,  rd_cnt_next;
  logic [CNT_W-1:0] rt_cnt_reg,  rt_cnt_next;
  logic             open_reg,    open_next;
  logic             max_seen_reg, max_seen_next;

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
    bump = (c == SAT) ? c : c + 1'b1;
  endfunction

  // ==========================================================
  // Cycles since event, one on its edge so exact minima pass; saturate
  // ==========================================================
  always_comb begin
    act_cnt_next  = act_in    ? CNT_W'(1) : bump(act_cnt_reg);
    pre_cnt_next  = pre_in    ? CNT_W'(1) : bump(pre_cnt_reg);
    rd_cnt_next   = rd_in     ? CNT_W'(1) : bump(rd_cnt_reg);
    rt_cnt_next   = retire_in ? CNT_W'(1) : bump(rt_cnt_reg);
    open_next     = act_in ? 1'b1 : (pre_in ? 1'b0 : open_reg);
    max_seen_next = act_in ? 1'b0 : max_seen_reg | viol_out[2];
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      act_cnt_reg  <= SAT;
      pre_cnt_reg  <= SAT;
      rd_cnt_reg   <= SAT;
      rt_cnt_reg   <= SAT;
      open_reg     <= 1'b0;
      max_seen_reg <= 1'b0;
    end else begin
      act_cnt_reg  <= act_cnt_next;
      pre_cnt_reg  <= pre_cnt_next;
      rd_cnt_reg   <= rd_cnt_next;
      rt_cnt_reg   <= rt_cnt_next;
      open_reg     <= open_next;
      max_seen_reg <= max_seen_next;
    end
  end

  // ==========================================================
  // Interval checks against the far end's obligations
  // ==========================================================
  always_comb begin
    viol_out[0] = act_in && (act_cnt_reg < CNT_W'(RC_CYC));
    viol_out[1] = pre_in && open_reg && (act_cnt_reg < CNT_W'(RAS_CYC));
    viol_out[2] = open_reg && !max_seen_reg && (act_cnt_reg > CNT_W'(RASX_CYC));
    viol_out[3] = act_in && (pre_cnt_reg < CNT_W'(RP_CYC));
    viol_out[4] = rw_in && (act_cnt_reg < CNT_W'(RCD_CYC));
    viol_out[5] = pre_in && (rd_cnt_reg < CNT_W'(`RDP_MIN));
    viol_out[6] = pre_in && (rt_cnt_reg < CNT_W'(`RTP_MIN));
  end

endmodule
`default_nettype wire

// File: verilog/bank_command_timing_guard.sv
// Notes on behaviour
// - Core sees activate-to-column delay one cycle longer than the pins.
// - Read data driven after programmable latency, 9 or 8 up to 12 cycles.
// - Every row, column, mask and extended packet lasts exactly 4 cycles.
// - Embedded precharge takes effect 4 cycles after its packet.
`timescale 1ns/1ps
`default_nettype none
`include "bank_guard_cfg.svh"

module bank_command_timing_guard #(
  parameter int  BANKS          = `BANK_COUNT,
  parameter bit  FAST_BIN       = 1'b1,
  parameter int  LINK_PERIOD_NS = `LINK_PERIOD_NS,
  parameter int  RAS_MAX_CYC    = `RAS_MAX_NS / `LINK_PERIOD_NS
) (
  // System clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_b_in,
  // Configuration (system domain)
  input  wire logic [`LAT_W-1:0]        read_latency_in,
  // Link clock
  input  wire logic                     link_clk_in,
  // Row bus, first cycle of a packet
  input  wire logic                     row_start_in,
  input  wire logic                     row_op_in,
  input  wire logic [$clog2(BANKS)-1:0] row_bank_in,
  // Column bus, first cycle of a packet
  input  wire logic                     col_start_in,
  input  wire logic [2:0]               col_op_in,
  input  wire logic [$clog2(BANKS)-1:0] col_bank_in,
  // Write data strobe from controller
  input  wire logic                     write_data_in,
  // Core commands (link domain)
  output logic                          core_activate_out,
  output logic                          core_precharge_out,
  output logic                          core_read_out,
  output logic                          core_write_out,
  output logic [$clog2(BANKS)-1:0]      core_bank_out,
  // Data timing (link domain)
  output logic                          read_drive_out,
  output logic                          write_capture_out,
  // Sticky interval violations (system domain)
  output logic [11:0]                   viol_out
);

  localparam int BW  = $clog2(BANKS);
  localparam int CNT = `CNT_W;
  localparam logic [`LAT_W-1:0] LAT_MIN = FAST_BIN ? `LAT_W'(`CAC_FAST) : `LAT_W'(`CAC_SLOW);
  localparam logic [`LAT_W-1:0] LAT_MAX = `LAT_W'(`CAC_MAX);

  // ==========================================================
  // Reset into link domain; latency taken only in reset
  // ==========================================================
  logic              lrst_meta_reg, lrst_reg;
  logic [`LAT_W-1:0] lat_meta_reg, lat_reg;

  always_ff @(posedge link_clk_in) begin
    lrst_meta_reg <= rst_b_in;
    lrst_reg      <= lrst_meta_reg;
    lat_meta_reg  <= read_latency_in;
    lat_reg       <= lrst_reg ? lat_reg : lat_meta_reg;
  end

  // ==========================================================
  // Packet framing: a start inside a packet is ignored
  // ==========================================================
  logic [2:0] row_left_reg, row_left_next;
  logic [2:0] col_left_reg, col_left_next;
  logic       row_take, col_take;
  bank_guard_pkg::col_op_type cop;

  always_comb begin
    cop = bank_guard_pkg::col_op_type'(col_op_in);
    row_take      = row_start_in && (row_left_reg == 3'h0);
    col_take      = col_start_in && (col_left_reg == 3'h0);
    row_left_next = row_take ? 3'(`PACKET_CYC - 1) :
                    (row_left_reg != 3'h0) ? row_left_reg - 3'h1 : 3'h0;
    col_left_next = col_take ? 3'(`PACKET_CYC - 1) :
                    (col_left_reg != 3'h0) ? col_left_reg - 3'h1 : 3'h0;
  end

  // Decoded events of taken packets
  logic row_act, row_pre, col_rd, col_wr, col_rw, col_rt, col_rtap, col_emb;
  logic col_rtr_kind;

  always_comb begin
    row_act  = row_take && (row_op_in == bank_guard_pkg::ROW_BANK_ACTIVATE);
    row_pre  = row_take && (row_op_in == bank_guard_pkg::ROW_PRECHARGE);
    col_rd   = col_take && (cop == bank_guard_pkg::COL_READ ||
                            cop == bank_guard_pkg::COL_READ_AUTO_PRECHARGE);
    col_wr   = col_take && (cop == bank_guard_pkg::COL_WRITE);
    col_rw   = col_rd || col_wr;
    col_rtap = col_take && (cop == bank_guard_pkg::COL_RETIRE_AUTO_PRECHARGE);
    col_rt   = col_take && (cop == bank_guard_pkg::COL_RETIRE) || col_rtap;
    // column and extended precharges join the precharge path
    col_emb  = col_take && (cop == bank_guard_pkg::COL_READ_AUTO_PRECHARGE ||
                            cop == bank_guard_pkg::COL_COLUMN_PRECHARGE ||
                            cop == bank_guard_pkg::COL_EXTENDED_PRECHARGE) || col_rtap;
    col_rtr_kind = col_rt || (col_take && cop == bank_guard_pkg::COL_BYTE_MASK);
  end

  // ==========================================================
  // Embedded precharge offset, read latency, write delay
  // ==========================================================
  logic [`OFFP_CYC-1:0]    emb_pipe_reg, emb_pipe_next;
  logic [BW-1:0]           emb_bank_reg [`OFFP_CYC];
  logic [BW-1:0]           emb_bank_next [`OFFP_CYC];
  logic [`CAC_MAX-1:0]     rd_pipe_reg, rd_pipe_next;
  logic [`CWD_CYC-1:0]     wr_pipe_reg, wr_pipe_next;
  logic [`LAT_W-1:0]       lat_use;
  logic                    pre_eff, emb_due;
  logic [BW-1:0]           pre_bank;

  always_comb begin
    // precharge acts four cycles after its packet
    emb_pipe_next    = {emb_pipe_reg[`OFFP_CYC-2:0], col_emb};
    emb_bank_next[0] = col_bank_in;
    for (int i = 1; i < `OFFP_CYC; i++) begin
      emb_bank_next[i] = emb_bank_reg[i-1];
    end
    emb_due  = emb_pipe_reg[`OFFP_CYC-1];
    // Row precharge wins a same-cycle clash; the spacing check flags it
    pre_eff  = row_pre || emb_due;
    pre_bank = row_pre ? row_bank_in : emb_bank_reg[`OFFP_CYC-1];
    // clamp latency into the legal window
    lat_use  = (lat_reg < LAT_MIN) ? LAT_MIN : (lat_reg > LAT_MAX) ? LAT_MAX : lat_reg;
    rd_pipe_next = {rd_pipe_reg[`CAC_MAX-2:0], col_rd};
    wr_pipe_next = {wr_pipe_reg[`CWD_CYC-2:0], col_wr};
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_reg) begin
      row_left_reg <= 3'h0;
      col_left_reg <= 3'h0;
      emb_pipe_reg <= '0;
      rd_pipe_reg  <= '0;
      wr_pipe_reg  <= '0;
      for (int i = 0; i < `OFFP_CYC; i++) begin
        emb_bank_reg[i] <= '0;
      end
    end else begin
      row_left_reg <= row_left_next;
      col_left_reg <= col_left_next;
      emb_pipe_reg <= emb_pipe_next;
      rd_pipe_reg  <= rd_pipe_next;
      wr_pipe_reg  <= wr_pipe_next;
      emb_bank_reg <= emb_bank_next;
    end
  end

  // ==========================================================
  // Core command outputs
  // ==========================================================
  logic             act_q_reg, pre_q_reg, col_rd_q_reg, col_wr_q_reg;
  logic [BW-1:0]    row_bank_q_reg, col_bank_q_reg;
  logic             core_act_next, core_pre_next, core_rd_next, core_wr_next;
  logic [BW-1:0]    core_bank_next;
  logic             rdrv_next, wcap_next;

  always_comb begin
    // column path lags the row path by one extra cycle
    core_act_next  = row_act;
    core_pre_next  = pre_eff;
    core_rd_next   = col_rd_q_reg;
    core_wr_next   = col_wr_q_reg;
    core_bank_next = (row_act || pre_eff) ? (row_act ? row_bank_in : pre_bank)
                                          : col_bank_q_reg;
    // Output flop adds one, so tap one stage earlier
    rdrv_next      = rd_pipe_reg[lat_use - `LAT_W'(2)];
    // write data taken exactly six cycles after the write
    wcap_next      = wr_pipe_reg[`CWD_CYC-2];
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_reg) begin
      col_rd_q_reg       <= 1'b0;
      col_wr_q_reg       <= 1'b0;
      col_bank_q_reg     <= '0;
      core_activate_out  <= 1'b0;
      core_precharge_out <= 1'b0;
      core_read_out      <= 1'b0;
      core_write_out     <= 1'b0;
      core_bank_out      <= '0;
      read_drive_out     <= 1'b0;
      write_capture_out  <= 1'b0;
    end else begin
      col_rd_q_reg       <= col_rd;
      col_wr_q_reg       <= col_wr;
      col_bank_q_reg     <= col_bank_in;
      core_activate_out  <= core_act_next;
      core_precharge_out <= core_pre_next;
      core_read_out      <= core_rd_next;
      core_write_out     <= core_wr_next;
      core_bank_out      <= core_bank_next;
      read_drive_out     <= rdrv_next;
      write_capture_out  <= wcap_next;
    end
  end

  // ==========================================================
  // Per-bank interval trackers
  // ==========================================================
  logic [6:0] bank_viol [BANKS];
  logic [6:0] bank_viol_or;

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    bank_timer #(
      .CNT_W    (CNT),
      .RC_CYC   (FAST_BIN ? `RC_FAST : `RC_SLOW),
      .RAS_CYC  (FAST_BIN ? `RAS_MIN_FAST : `RAS_MIN_SLOW),
      .RASX_CYC (RAS_MAX_CYC),
      .RP_CYC   (FAST_BIN ? `RP_FAST : `RP_SLOW),
      .RCD_CYC  (FAST_BIN ? `RCD_FAST : `RCD_SLOW)
    ) u_timer (
      .clk_in    (link_clk_in),
      .rst_b_in  (lrst_reg),
      .act_in    (row_act && row_bank_in == BW'(b)),
      .pre_in    (pre_eff && pre_bank == BW'(b)),
      .rw_in     (col_rw && col_bank_in == BW'(b)),
      .rd_in     (col_rd && col_bank_in == BW'(b)),
      .retire_in (col_rt && col_bank_in == BW'(b)),
      .viol_out  (bank_viol[b])
    );
  end

  always_comb begin
    bank_viol_or = '0;
    for (int b = 0; b < BANKS; b++) begin
      bank_viol_or = bank_viol_or | bank_viol[b];
    end
  end

  // ==========================================================
  // Device-wide spacing and sticky violation flags
  // ==========================================================
  logic [CNT-1:0] pp_reg, rr_reg, cc_reg, wr_reg;
  logic [CNT-1:0] pp_next, rr_next, cc_next, wr_next;
  logic [11:0]    flag_reg, flag_next, hit;

  function automatic logic [CNT-1:0] bump(input logic [CNT-1:0] c);
    bump = (c == {CNT{1'b1}}) ? c : c + 1'b1;
  endfunction

  always_comb begin
    pp_next = pre_eff ? CNT'(1) : bump(pp_reg);
    rr_next = row_act ? CNT'(1) : bump(rr_reg);
    cc_next = col_take && !col_rtr_kind ? CNT'(1) : bump(cc_reg);
    wr_next = col_wr ? CNT'(1) : bump(wr_reg);
    hit     = {5'h00, bank_viol_or};
    hit[bank_guard_pkg::V_PP]  = pre_eff && (pp_reg < CNT'(`PP_MIN) || (row_pre && emb_due));
    hit[bank_guard_pkg::V_RR]  = row_act && (rr_reg < CNT'(`RR_MIN));
    hit[bank_guard_pkg::V_CC]  = col_take && !col_rtr_kind && (cc_reg < CNT'(`CC_MIN));
    // write to retire or byte mask
    hit[bank_guard_pkg::V_RTR] = col_take && col_rtr_kind && (wr_reg < CNT'(`RTR_MIN));
    // data strobe off the six-cycle slot
    hit[bank_guard_pkg::V_CWD] = write_data_in && !wr_pipe_reg[`CWD_CYC-1];
    flag_next = flag_reg | hit;
  end

  always_ff @(posedge link_clk_in) begin
    if (!lrst_reg) begin
      pp_reg   <= '1;
      rr_reg   <= '1;
      cc_reg   <= '1;
      wr_reg   <= '1;
      flag_reg <= '0;
    end else begin
      pp_reg   <= pp_next;
      rr_reg   <= rr_next;
      cc_reg   <= cc_next;
      wr_reg   <= wr_next;
      flag_reg <= flag_next;
    end
  end

  // ==========================================================
  // Flags back to system domain; sticky so level sync suffices
  // ==========================================================
  logic [11:0] viol_meta_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      viol_meta_reg <= '0;
      viol_out      <= '0;
    end else begin
      viol_meta_reg <= flag_reg;
      viol_out      <= viol_meta_reg;
    end
  end

endmodule
`default_nettype wire

// File: bench/bank_guard_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "bank_guard_cfg.svh"
module bank_guard_sva #(parameter int BANKS = 32) (
  // Clocks and reset
  input wire logic                     clk_in,
  input wire logic                     rst_b_in,
  input wire logic                     link_clk_in,
  // Controller side
  input wire logic [`LAT_W-1:0]        read_latency_in,
  input wire logic                     row_start_in,
  input wire logic                     row_op_in,
  input wire logic [$clog2(BANKS)-1:0] row_bank_in,
  input wire logic                     col_start_in,
  input wire logic [2:0]               col_op_in,
  input wire logic [$clog2(BANKS)-1:0] col_bank_in,
  input wire logic                     write_data_in,
  // Core side and flags
  input wire logic                     core_activate_out,
  input wire logic                     core_precharge_out,
  input wire logic                     core_read_out,
  input wire logic                     core_write_out,
  input wire logic [$clog2(BANKS)-1:0] core_bank_out,
  input wire logic                     read_drive_out,
  input wire logic                     write_capture_out,
  input wire logic [11:0]              viol_out
);
  // ==========================================
  // Link domain timing; sticky flags sampled slowly is still exact
  default clocking cb @(posedge link_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_act; row_start_in && !row_op_in |=> core_activate_out && core_bank_out == $past(row_bank_in); endproperty
  a_act: assert property (p_act) else $error("activate not passed on");
  property p_pre; row_start_in && row_op_in |=> core_precharge_out && core_bank_out == $past(row_bank_in); endproperty
  a_pre: assert property (p_pre) else $error("row precharge not passed on");
  property p_rd; col_start_in && (col_op_in == 3'h0 || col_op_in == 3'h2) |-> ##2 core_read_out; endproperty
  a_rd: assert property (p_rd) else $error("core read not one cycle later than row path");
  property p_rd_cause; core_read_out |-> $past(col_start_in, 2) && !$past(col_op_in[0], 2); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("core read without column read");
  property p_wr; col_start_in && col_op_in == 3'h1 |-> ##2 core_write_out ##4 write_capture_out; endproperty
  a_wr: assert property (p_wr) else $error("write path timing wrong");
  property p_cap_cause; write_capture_out |-> $past(col_start_in, 6) && $past(col_op_in, 6) == 3'h1; endproperty
  a_cap_cause: assert property (p_cap_cause) else $error("capture without write");
  property p_emb; col_start_in && col_op_in inside {3'h2, 3'h4, 3'h5, 3'h6} |-> ##5 core_precharge_out; endproperty
  a_emb: assert property (p_emb) else $error("embedded precharge offset wrong");
  property p_lat; col_start_in && (col_op_in == 3'h0 || col_op_in == 3'h2) |-> ##[9:12] read_drive_out; endproperty
  a_lat: assert property (p_lat) else $error("read data outside latency range");
  property p_sticky; 1'b1 |=> (viol_out & $past(viol_out)) == $past(viol_out); endproperty
  a_sticky: assert property (p_sticky) else $error("violation flag dropped");
  c_read: cover property (read_drive_out);
  c_write: cover property (write_capture_out);
  c_viol: cover property (viol_out != 12'h000);
endmodule
`default_nettype wire

// File: bench/controller_model.sv
`timescale 1ns/1ps
`default_nettype none
module controller_model (
  // Link clock
  input  wire logic link_clk_in,
  // Row and column buses
  output logic       row_start_out,
  output logic       row_op_out,
  output logic [4:0] row_bank_out,
  output logic       col_start_out,
  output logic [2:0] col_op_out,
  output logic [4:0] col_bank_out,
  // Write data strobe
  output logic       write_data_out
);
  // ==========================================
  // Buses idle until the first packet
  initial begin
    {row_start_out, row_op_out, row_bank_out} = 7'h00;
    {col_start_out, col_op_out, col_bank_out, write_data_out} = 10'h000;
  end
  task automatic row_cmd(input logic op, input logic [4:0] bk);
    @(posedge link_clk_in);
    {row_start_out, row_op_out, row_bank_out} <= {1'b1, op, bk};
    fork
      begin
        @(posedge link_clk_in);
        row_start_out <= 1'b0;
        repeat (2) @(posedge link_clk_in);
        {row_op_out, row_bank_out} <= ~{op, bk}; // Released lines never keep old value
      end
    join_none
  endtask
  task automatic col_cmd(input logic [2:0] op, input logic [4:0] bk, input logic late);
    @(posedge link_clk_in);
    {col_start_out, col_op_out, col_bank_out} <= {1'b1, op, bk};
    fork
      begin
        @(posedge link_clk_in);
        col_start_out <= 1'b0;
        repeat (2) @(posedge link_clk_in);
        {col_op_out, col_bank_out} <= ~{op, bk};
      end
      // Data lands exactly six cycles after the taken start unless told late
      if (op == 3'h1) begin
        repeat (late ? 7 : 6) @(posedge link_clk_in);
        write_data_out <= 1'b1;
        @(posedge link_clk_in);
        write_data_out <= 1'b0;
      end
    join_none
  endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================
  // Signals and scoreboard
  logic        clk_in = 1'b0;
  logic        link_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [3:0]  read_latency_in = 4'h0;
  wire logic   row_start_in, row_op_in, col_start_in, write_data_in;
  wire logic [4:0] row_bank_in, col_bank_in;
  wire logic [2:0] col_op_in;
  logic        core_activate_out, core_precharge_out, core_read_out, core_write_out;
  logic        read_drive_out, write_capture_out;
  logic [4:0]  core_bank_out;
  logic [11:0] viol_out;
  logic [31:0] lcyc = 32'h0;
  logic [15:0] seed = 16'hB12A;
  logic [31:0] exp_q[6][$];
  int          mismatches = 0;
  int          check_count = 0;
  wire logic [5:0] outs = {write_capture_out, read_drive_out, core_write_out,
                           core_read_out, core_precharge_out, core_activate_out};
  // Clocks; link clock offset so phases never line up
  always #2.5 clk_in = ~clk_in;
  initial begin
    #17.3;
    forever #62.5 link_clk_in = ~link_clk_in;
  end
  always @(posedge link_clk_in) lcyc <= lcyc + 32'h1;
  // Short maximum activation time keeps the run brief
  bank_command_timing_guard #(.RAS_MAX_CYC(40)) bank_command_timing_guard_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .read_latency_in(read_latency_in),
    .link_clk_in(link_clk_in), .row_start_in(row_start_in), .row_op_in(row_op_in),
    .row_bank_in(row_bank_in), .col_start_in(col_start_in), .col_op_in(col_op_in),
    .col_bank_in(col_bank_in), .write_data_in(write_data_in),
    .core_activate_out(core_activate_out), .core_precharge_out(core_precharge_out),
    .core_read_out(core_read_out), .core_write_out(core_write_out),
    .core_bank_out(core_bank_out), .read_drive_out(read_drive_out),
    .write_capture_out(write_capture_out), .viol_out(viol_out));
  controller_model controller_model_i (
    .link_clk_in(link_clk_in), .row_start_out(row_start_in), .row_op_out(row_op_in),
    .row_bank_out(row_bank_in), .col_start_out(col_start_in), .col_op_out(col_op_in),
    .col_bank_out(col_bank_in), .write_data_out(write_data_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Kinds: 0 act, 1 pre, 2 read, 3 write, 4 read data, 5 write data
  function automatic void note(input int k, input int due, input logic [4:0] bk);
    exp_q[k].push_back({27'(due), bk});
  endfunction
  // Each pulse is matched against the oldest note of its kind
  always @(posedge link_clk_in) begin
    #1;
    for (int k = 0; k < 6; k++) begin
      if (outs[k] === 1'b1 && exp_q[k].size() == 0) check(32'h1, 32'h0);
      else if (outs[k] === 1'b1) check({lcyc[26:0], k < 4 ? core_bank_out : 5'h00}, exp_q[k].pop_front());
    end
  end
  task automatic do_reset();
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (5) @(posedge link_clk_in);
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int k = 0; k < 6; k++) exp_q[k].delete();
    repeat (4) @(posedge link_clk_in);
  endtask
  // spacing set by caller; r 1 row, 0 column, 2 none; op 8 late write
  task automatic cmd(input int r, input int op, input logic [4:0] bk, input int gap);
    int base;
    int lat;
    if (r == 2) return;
    lat = read_latency_in < 4'h9 ? 9 : (read_latency_in > 4'hC ? 12 : int'(read_latency_in));
    if (r == 1) controller_model_i.row_cmd(op[0], bk);
    else controller_model_i.col_cmd(op == 8 ? 3'h1 : 3'(op), bk, op == 8);
    base = int'(lcyc) - 1;
    if (r == 1) note(op, base + 3, bk);
    if (r == 0 && op inside {0, 2}) note(2, base + 4, bk);
    if (r == 0 && op inside {0, 2}) note(4, base + 2 + lat, 5'h00);
    if (r == 0 && op inside {1, 8}) note(3, base + 4, bk);
    if (r == 0 && op inside {1, 8}) note(5, base + 8, 5'h00);
    if (r == 0 && op inside {2, 4, 5, 6}) note(1, base + 7, bk);
    repeat (gap - 1) @(posedge link_clk_in);
  endtask
  // Three commands on a random bank b (s=1 picks b^1), then flags and notes
  task automatic viol_case(input logic [11:0] exp, input int r0, o0, s0, g0,
                           input int r1, o1, s1, g1, input int r2, o2, s2, g2);
    logic [4:0] b;
    seed = lfsr_next(seed);
    b = seed[4:0];
    do_reset();
    cmd(r0, o0, b ^ 5'(s0), g0);
    cmd(r1, o1, b ^ 5'(s1), g1);
    cmd(r2, o2, b ^ 5'(s2), g2);
    repeat (8) @(posedge link_clk_in);
    check({20'h0, viol_out}, {20'h0, exp});
    check(32'(exp_q[0].size() + exp_q[1].size() + exp_q[2].size() + exp_q[3].size()
              + exp_q[4].size() + exp_q[5].size()), 32'h0);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    viol_case(12'h100, 1,0,0,4, 1,0,1,12, 2,0,0,0);
    viol_case(12'h080, 1,1,0,4, 1,1,1,12, 2,0,0,0);
    viol_case(12'h002, 1,0,0,12, 1,1,0,12, 2,0,0,0);
    viol_case(12'h009, 1,0,0,22, 1,1,0,8, 1,0,0,12);
    viol_case(12'h010, 1,0,0,5, 0,0,0,12, 2,0,0,0);
    viol_case(12'h020, 1,0,0,20, 0,0,0,2, 1,1,0,12);
    viol_case(12'h040, 1,0,0,20, 0,3,0,2, 1,1,0,12);
    viol_case(12'h400, 0,1,0,4, 0,3,0,12, 2,0,0,0);
    viol_case(12'h400, 0,1,0,4, 0,7,0,12, 2,0,0,0);
    viol_case(12'h800, 0,8,0,12, 2,0,0,0, 2,0,0,0);
    viol_case(12'h080, 0,5,0,8, 1,1,1,12, 2,0,0,0);
    viol_case(12'h080, 0,6,0,8, 1,1,1,12, 2,0,0,0);
    viol_case(12'h004, 1,0,0,50, 2,0,0,0, 2,0,0,0);
    viol_case(12'h000, 1,0,0,13, 0,1,0,8, 0,4,0,12);
    viol_case(12'h000, 1,0,0,18, 0,2,0,12, 2,0,0,0);
    // Latency field below the lower clamp limit, inside, at and beyond the upper, reads back to back
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in) read_latency_in <= (i == 0) ? 4'h0 : (i == 1) ? 4'hA : (i == 2) ? 4'hC : 4'hF;
      viol_case(12'h000, 0,0,0,4, 0,0,0,12, 2,0,0,0);
    end
    complete_run();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end
endmodule
bind bank_command_timing_guard bank_guard_sva #(.BANKS(BANKS)) bank_guard_sva_i (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .link_clk_in(link_clk_in),
  .read_latency_in(read_latency_in), .row_start_in(row_start_in), .row_op_in(row_op_in),
  .row_bank_in(row_bank_in), .col_start_in(col_start_in), .col_op_in(col_op_in),
  .col_bank_in(col_bank_in), .write_data_in(write_data_in),
  .core_activate_out(core_activate_out), .core_precharge_out(core_precharge_out),
  .core_read_out(core_read_out), .core_write_out(core_write_out),
  .core_bank_out(core_bank_out), .read_drive_out(read_drive_out),
  .write_capture_out(write_capture_out), .viol_out(viol_out));
`default_nettype wire
